// File: dscc_defs.svh
`ifndef DSCC_DEFS_SVH
`define DSCC_DEFS_SVH
// Wishbone register offsets (byte addresses)
`define DSCC_OFS_CTRL 8'h00
`define DSCC_OFS_CMD 8'h04
`define DSCC_OFS_SEL 8'h08
`define DSCC_OFS_MEAS 8'h0C
`define DSCC_OFS_INWORD 8'h10
`define DSCC_OFS_CMDSTAT 8'h14
`define DSCC_OFS_FARSP 8'h18
`define DSCC_OFS_NEARSP 8'h1C
`define DSCC_OFS_ANALOG 8'h20
`define DSCC_OFS_OFFSET 8'h24
`define DSCC_OFS_PRESET 8'h28
`define DSCC_OFS_ALTSP 8'h2C
// System command codes
`define DSCC_CMD_TEACH_FAR 8'h41
`define DSCC_CMD_TEACH_NEAR 8'h42
`define DSCC_CMD_TEACH_WIN 8'h4B
`define DSCC_CMD_TEACH_ALT 8'h4C
`define DSCC_CMD_RESTART 8'h80
`define DSCC_CMD_FACTORY 8'h82
`define DSCC_CMD_REVOKE 8'hA0
`define DSCC_CMD_ACCEPT 8'hA1
`define DSCC_CMD_FORCE_ON 8'hB0
`define DSCC_CMD_FORCE_OFF 8'hB1
`define DSCC_CMD_STD_PRIO 8'hB2
`define DSCC_CMD_ANA_MIN 8'hC3
`define DSCC_CMD_ANA_MAX 8'hC4
`define DSCC_CMD_PRESET 8'hD4
// Scale exponents
`define DSCC_SCALE_STD 8'hFC
`define DSCC_SCALE_HR 8'hFB
// Distance limits and reserved codes
`define DSCC_DIST_MAX 16'sh7D00
`define DSCC_DIST_MIN (-16'sh7D00)
`define DSCC_DIST_NONE 16'h7FFC
`define DSCC_DIST_ABOVE 16'h7FF8
`define DSCC_DIST_BELOW 16'h8008
// Teach target selector values
`define DSCC_SEL_CH1A 8'h00
`define DSCC_SEL_CH1B 8'h01
`define DSCC_SEL_CH2 8'h02
`define DSCC_SEL_BOTH 8'hFF
// Status bit positions
`define DSCC_ST_CH1 0
`define DSCC_ST_CH2 1
`define DSCC_ST_MEAS 3
`define DSCC_ST_SIG 4
`define DSCC_ST_WARN 5
`define DSCC_ST_TOGGLE 7
// Control register bit positions
`define DSCC_CTRL_HIRES 0
`define DSCC_CTRL_INFUNC 1
// Link timing: 230.4 kBaud, 0.5 ms cycle, 250 MHz clock
`define DSCC_CLK_HZ 250000000
`define DSCC_BAUD 230400
`define DSCC_CYCLE_US 500
`endif

// File: dscc_pkg.sv
package dscc_pkg;
   typedef enum logic [1:0] {DSCC_PRIO_STD, DSCC_PRIO_ON, DSCC_PRIO_OFF} dscc_prio_t;
   typedef enum logic [1:0] {DSCC_ST_IDLE, DSCC_ST_EXEC, DSCC_ST_DONE} dscc_state_t;
endpackage

// File: dscc_core.sv
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "dscc_defs.svh"
// Notes on behaviour
// - Input word: status, scale, distance packed
// - Output word bit 0 switches emitter off
// - Cyclic exchange, 230.4 kBaud, 0.5 ms minimum
// - 0x41 teaches far, 0x42 near setpoint
// - 0x4B teaches both, 0x4C alternate far
// - 0x80 restarts software, settings kept
// - 0x82 restores factory user settings
// - 0xA0 clears storage accept flag
// - 0xA1 sets accept flag, raises upload event
// - 0xB0/0xB1 force emitter, override output bit
// - 0xB2 drops forcing, output bit effective again
// - Configured hardware input overrides everything
// - 0xC3/0xC4 capture analog low/high distance
// - 0xD4 stores offset so distance reads preset
// - Status bits 2,6 zero; all zero after reset
// - Status bit 3 set in normal measurement
// - Status bit 4 means signal sufficient
// - Status bits 0,1 carry channel states
// - Status bit 7 toggles on triggered change
// - Status bit 5 warns; cause in extended status
// - Scale 0xFC standard, 0xFB high resolution
// - Distance beyond plus/minus 32000 replaced by a reserved code
// - Reserved codes: none, above, below range
// - Selector picks channel one, two or both
module dscc_core
   import dscc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // Link side process data
   input wire logic [7:0] master_output_word_i,
   input wire logic pd_out_valid_i,
   output logic [31:0] device_input_word_o,
   output logic pd_in_strobe_o,
   // Measurement front end
   input wire logic meas_valid_i,
   input wire logic [15:0] meas_dist_i,
   input wire logic meas_none_i,
   input wire logic meas_trigger_i,
   input wire logic signal_ok_i,
   input wire logic warning_i,
   input wire logic switch_channel_one_i,
   input wire logic switch_channel_two_i,
   input wire logic startup_i,
   input wire logic teaching_i,
   input wire logic hw_input_level_i,
   // Effects
   output logic emitter_on_o,
   output logic restart_o,
   output logic factory_reset_o,
   output logic upload_event_o,
   output logic storage_accept_flag_o,
   output logic cmd_error_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Timing constants
   localparam int unsigned PD_CYC = (`DSCC_CLK_HZ / 1000000) * `DSCC_CYCLE_US;

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [1:0] ctrl_reg;
   logic [7:0] sel_reg;
   logic [7:0] cmd_reg;
   logic cmd_pend_reg;
   logic [15:0] far_reg [2];
   logic [15:0] near_reg [2];
   logic [15:0] alt_reg [2];
   logic [15:0] ana_lo_reg;
   logic [15:0] ana_hi_reg;
   logic [15:0] offset_reg;
   logic [15:0] preset_reg;
   logic [15:0] dist_reg;
   logic toggle_reg;
   logic accept_reg;
   dscc_prio_t prio_reg;
   logic emit_off_reg;
   logic err_reg;
   logic restart_reg;
   logic factory_reg;
   logic event_reg;
   logic [31:0] word_reg;
   logic [18:0] cyc_cnt_reg;
   logic strobe_reg;
   logic ack_reg;
   logic aerr_reg;
   logic [31:0] rdat_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode; a command write is refused while one is still pending
   wire bus_req = wb_cyc_i && wb_stb_i && !ack_reg && !aerr_reg;
   wire wr = bus_req && wb_we_i;
   wire hit_ctrl = wb_adr_i == `DSCC_OFS_CTRL;
   wire hit_cmd = wb_adr_i == `DSCC_OFS_CMD;
   wire hit_sel = wb_adr_i == `DSCC_OFS_SEL;
   wire hit_preset = wb_adr_i == `DSCC_OFS_PRESET;
   wire hit_ro = wb_adr_i == `DSCC_OFS_MEAS || wb_adr_i == `DSCC_OFS_INWORD
      || wb_adr_i == `DSCC_OFS_CMDSTAT || wb_adr_i == `DSCC_OFS_FARSP
      || wb_adr_i == `DSCC_OFS_NEARSP || wb_adr_i == `DSCC_OFS_ANALOG
      || wb_adr_i == `DSCC_OFS_OFFSET || wb_adr_i == `DSCC_OFS_ALTSP;
   wire hit_any = hit_ctrl || hit_cmd || hit_sel || hit_preset || hit_ro;
   wire cmd_wr = wr && hit_cmd && wb_sel_i[0];

   // Command decode
   wire [7:0] c = cmd_reg;
   wire is_teach = c == `DSCC_CMD_TEACH_FAR || c == `DSCC_CMD_TEACH_NEAR
      || c == `DSCC_CMD_TEACH_WIN || c == `DSCC_CMD_TEACH_ALT;
   wire known = is_teach || c == `DSCC_CMD_RESTART || c == `DSCC_CMD_FACTORY
      || c == `DSCC_CMD_REVOKE || c == `DSCC_CMD_ACCEPT || c == `DSCC_CMD_FORCE_ON
      || c == `DSCC_CMD_FORCE_OFF || c == `DSCC_CMD_STD_PRIO || c == `DSCC_CMD_ANA_MIN
      || c == `DSCC_CMD_ANA_MAX || c == `DSCC_CMD_PRESET;
   wire do_cmd = cmd_pend_reg;
   // Teach target: 0 or 1 is channel one, 2 channel two, 255 both
   wire tgt1 = sel_reg == `DSCC_SEL_CH1A || sel_reg == `DSCC_SEL_CH1B
      || sel_reg == `DSCC_SEL_BOTH;
   wire tgt2 = sel_reg == `DSCC_SEL_CH2 || sel_reg == `DSCC_SEL_BOTH;
   wire [1:0] tgt = {tgt2, tgt1};

   ////////////////////////////////////////////////////////////////////////////
   // Distance conditioning: offset, range check, reserved codes
   wire signed [16:0] adj = 17'($signed(meas_dist_i)) + 17'($signed(offset_reg));
   wire above = adj > 17'(`DSCC_DIST_MAX);
   wire below = adj < 17'(`DSCC_DIST_MIN);
   wire [15:0] dist_next = meas_none_i ? `DSCC_DIST_NONE :
      above ? `DSCC_DIST_ABOVE : below ? `DSCC_DIST_BELOW : adj[15:0];
   // Preset offset so that the present raw reading shows as the preset
   wire [15:0] offset_next = 16'(preset_reg - meas_dist_i);

   ////////////////////////////////////////////////////////////////////////////
   // Emitter priority: hardware input, then forced state, then output word
   wire emit_on = ctrl_reg[`DSCC_CTRL_INFUNC] ? hw_input_level_i :
      prio_reg == DSCC_PRIO_ON ? 1'b1 : prio_reg == DSCC_PRIO_OFF ? 1'b0 :
      !emit_off_reg;
   assign emitter_on_o = emit_on;

   // Status byte; bits 2 and 6 tied low
   wire measuring = emit_on && !startup_i && !teaching_i;
   wire [7:0] status;
   assign status[`DSCC_ST_CH1] = switch_channel_one_i;
   assign status[`DSCC_ST_CH2] = switch_channel_two_i;
   assign status[2] = 1'b0;
   assign status[`DSCC_ST_MEAS] = measuring;
   assign status[`DSCC_ST_SIG] = signal_ok_i;
   assign status[`DSCC_ST_WARN] = warning_i && measuring;
   assign status[6] = 1'b0;
   assign status[`DSCC_ST_TOGGLE] = toggle_reg;
   wire [7:0] scale = ctrl_reg[`DSCC_CTRL_HIRES] ? `DSCC_SCALE_HR : `DSCC_SCALE_STD;
   wire pd_tick = cyc_cnt_reg == 19'(PD_CYC - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Bus registers and command capture
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= 2'h0;
         sel_reg <= `DSCC_SEL_CH1A;
         preset_reg <= 16'h0000;
         cmd_reg <= 8'h00;
         cmd_pend_reg <= 1'b0;
      end else begin
         if (wr && hit_ctrl && wb_sel_i[0]) ctrl_reg <= wb_dat_i[1:0];
         if (wr && hit_sel && wb_sel_i[0]) sel_reg <= wb_dat_i[7:0];
         if (wr && hit_preset && wb_sel_i[0]) preset_reg[7:0] <= wb_dat_i[7:0];
         if (wr && hit_preset && wb_sel_i[1]) preset_reg[15:8] <= wb_dat_i[15:8];
         if (cmd_wr && !cmd_pend_reg) begin
            cmd_reg <= wb_dat_i[7:0];
         end
         cmd_pend_reg <= cmd_wr && !cmd_pend_reg;
      end
   end

   // Command execution, one cycle after the write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prio_reg <= DSCC_PRIO_STD;
         accept_reg <= 1'b0;
         err_reg <= 1'b0;
         restart_reg <= 1'b0;
         factory_reg <= 1'b0;
         event_reg <= 1'b0;
         ana_lo_reg <= 16'h0000;
         ana_hi_reg <= 16'h0000;
         offset_reg <= 16'h0000;
      end else begin
         restart_reg <= do_cmd && c == `DSCC_CMD_RESTART;
         factory_reg <= do_cmd && c == `DSCC_CMD_FACTORY;
         event_reg <= do_cmd && c == `DSCC_CMD_ACCEPT;
         if (do_cmd) begin
            err_reg <= !known;
            case (c)
               `DSCC_CMD_REVOKE: accept_reg <= 1'b0;
               `DSCC_CMD_ACCEPT: accept_reg <= 1'b1;
               `DSCC_CMD_FORCE_ON: prio_reg <= DSCC_PRIO_ON;
               `DSCC_CMD_FORCE_OFF: prio_reg <= DSCC_PRIO_OFF;
               `DSCC_CMD_STD_PRIO: prio_reg <= DSCC_PRIO_STD;
               `DSCC_CMD_ANA_MIN: ana_lo_reg <= dist_reg;
               `DSCC_CMD_ANA_MAX: ana_hi_reg <= dist_reg;
               `DSCC_CMD_PRESET: offset_reg <= offset_next;
               `DSCC_CMD_FACTORY: begin
                  accept_reg <= 1'b0;
                  offset_reg <= 16'h0000;
                  ana_lo_reg <= 16'h0000;
                  ana_hi_reg <= 16'h0000;
                  prio_reg <= DSCC_PRIO_STD;
               end
               default: ;
            endcase
         end
      end
   end

   // Setpoints per channel
   generate
      for (genvar ch = 0; ch < 2; ch++) begin : g_ch
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               far_reg[ch] <= 16'h0000;
               near_reg[ch] <= 16'h0000;
               alt_reg[ch] <= 16'h0000;
            end else if (do_cmd && c == `DSCC_CMD_FACTORY) begin
               far_reg[ch] <= 16'h0000;
               near_reg[ch] <= 16'h0000;
               alt_reg[ch] <= 16'h0000;
            end else if (do_cmd && tgt[ch]) begin
               case (c)
                  `DSCC_CMD_TEACH_FAR: far_reg[ch] <= dist_reg;
                  `DSCC_CMD_TEACH_NEAR: near_reg[ch] <= dist_reg;
                  `DSCC_CMD_TEACH_WIN: begin
                     // Window re-centred on the taught point, width rounded down to even
                     far_reg[ch] <= 16'(dist_reg + ((far_reg[ch] - near_reg[ch]) >>> 1));
                     near_reg[ch] <= 16'(dist_reg - ((far_reg[ch] - near_reg[ch]) >>> 1));
                  end
                  `DSCC_CMD_TEACH_ALT: alt_reg[ch] <= dist_reg;
                  default: ;
               endcase
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Measurement, output word and cyclic input word
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dist_reg <= `DSCC_DIST_NONE;
         toggle_reg <= 1'b0;
         emit_off_reg <= 1'b0;
         word_reg <= 32'h0000_0000;
         cyc_cnt_reg <= 19'h0_0000;
         strobe_reg <= 1'b0;
      end else begin
         if (meas_valid_i) dist_reg <= dist_next;
         if (meas_valid_i && meas_trigger_i && dist_next != dist_reg) begin
            toggle_reg <= !toggle_reg;
         end
         if (pd_out_valid_i) emit_off_reg <= master_output_word_i[0];
         cyc_cnt_reg <= pd_tick ? 19'h0_0000 : cyc_cnt_reg + 19'h0_0001;
         strobe_reg <= pd_tick;
         if (pd_tick) word_reg <= {dist_reg, scale, status};
      end
   end

   assign device_input_word_o = word_reg;
   assign pd_in_strobe_o = strobe_reg;
   assign restart_o = restart_reg;
   assign factory_reset_o = factory_reg;
   assign upload_event_o = event_reg;
   assign storage_accept_flag_o = accept_reg;
   assign cmd_error_o = err_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus answer: one cycle after the request, err on an unmapped address
   logic [31:0] rdat_next_c;
   always_comb begin
      rdat_next_c = 32'h0000_0000;
      case (wb_adr_i)
         `DSCC_OFS_CTRL: rdat_next_c = {30'h0, ctrl_reg};
         `DSCC_OFS_SEL: rdat_next_c = {24'h0, sel_reg};
         `DSCC_OFS_CMD: rdat_next_c = {24'h0, cmd_reg};
         `DSCC_OFS_MEAS: rdat_next_c = {16'h0, dist_reg};
         // Live word, the one that the next exchange will carry
         `DSCC_OFS_INWORD: rdat_next_c = {dist_reg, scale, status};
         `DSCC_OFS_CMDSTAT: rdat_next_c = {26'h0, prio_reg, cmd_pend_reg, accept_reg,
            emit_on, err_reg};
         `DSCC_OFS_FARSP: rdat_next_c = {far_reg[1], far_reg[0]};
         `DSCC_OFS_NEARSP: rdat_next_c = {near_reg[1], near_reg[0]};
         `DSCC_OFS_ANALOG: rdat_next_c = {ana_hi_reg, ana_lo_reg};
         `DSCC_OFS_OFFSET: rdat_next_c = {16'h0, offset_reg};
         `DSCC_OFS_ALTSP: rdat_next_c = {alt_reg[1], alt_reg[0]};
         `DSCC_OFS_PRESET: rdat_next_c = {16'h0, preset_reg};
         default: rdat_next_c = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         aerr_reg <= 1'b0;
         rdat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= bus_req && hit_any;
         aerr_reg <= bus_req && !hit_any;
         if (bus_req && !wb_we_i) rdat_reg <= rdat_next_c;
      end
   end
   assign wb_ack_o = ack_reg;
   assign wb_err_o = aerr_reg;
   assign wb_dat_o = rdat_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_cmd(logic [7:0] code);
      cmd_pend_reg && cmd_reg == code;
   endsequence

   AST_STATUS_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
      word_reg[2] == 1'b0 && word_reg[6] == 1'b0)
      else $error("reserved status bits not zero");
   AST_WORD_PACK: assert property (@(posedge clk_i) disable iff (rst_i)
      pd_tick |=> word_reg == {$past(dist_reg), $past(scale), $past(status)})
      else $error("input word packing wrong");
   AST_FORCE_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
      s_cmd(`DSCC_CMD_FORCE_OFF) ##1 !ctrl_reg[`DSCC_CTRL_INFUNC] |-> !emitter_on_o)
      else $error("forced off not honoured");
   AST_STD_PRIO: assert property (@(posedge clk_i) disable iff (rst_i)
      s_cmd(`DSCC_CMD_STD_PRIO) ##1 !ctrl_reg[`DSCC_CTRL_INFUNC]
      |-> emitter_on_o == !emit_off_reg)
      else $error("output bit not effective after release");
   AST_HW_PRIO: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_reg[`DSCC_CTRL_INFUNC] |-> emitter_on_o == hw_input_level_i)
      else $error("hardware input lost priority");
   AST_ACCEPT: assert property (@(posedge clk_i) disable iff (rst_i)
      s_cmd(`DSCC_CMD_ACCEPT) |=> storage_accept_flag_o && upload_event_o ##1 !upload_event_o)
      else $error("accept flag or event wrong");
   AST_REVOKE: assert property (@(posedge clk_i) disable iff (rst_i)
      s_cmd(`DSCC_CMD_REVOKE) |=> !storage_accept_flag_o)
      else $error("accept flag not cleared");
   AST_UNKNOWN: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_pend_reg && !known |=> cmd_error_o && $stable(prio_reg) && $stable(accept_reg))
      else $error("unknown command not rejected");
   AST_CLAMP: assert property (@(posedge clk_i) disable iff (rst_i)
      meas_valid_i && !meas_none_i && above |=> dist_reg == `DSCC_DIST_ABOVE)
      else $error("above range code missing");
   AST_SCALE: assert property (@(posedge clk_i) disable iff (rst_i)
      pd_tick && !ctrl_reg[`DSCC_CTRL_HIRES] |=> word_reg[15:8] == `DSCC_SCALE_STD)
      else $error("scale byte wrong");
   AST_TEACH_FAR: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_pend_reg && c == `DSCC_CMD_TEACH_FAR && tgt1 |=> far_reg[0] == $past(dist_reg))
      else $error("far setpoint not taught");
   AST_TEACH_ALT: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_pend_reg && c == `DSCC_CMD_TEACH_ALT && tgt2 |=> alt_reg[1] == $past(dist_reg))
      else $error("alternate setpoint not taught");
   AST_RESTART: assert property (@(posedge clk_i) disable iff (rst_i)
      s_cmd(`DSCC_CMD_RESTART) |=> restart_o ##1 !restart_o)
      else $error("restart pulse wrong");
   AST_FACTORY: assert property (@(posedge clk_i) disable iff (rst_i)
      s_cmd(`DSCC_CMD_FACTORY) |=> factory_reset_o && !storage_accept_flag_o)
      else $error("factory values not restored");
   AST_MEAS_BIT: assert property (@(posedge clk_i) disable iff (rst_i)
      startup_i || teaching_i || !emitter_on_o |-> !status[`DSCC_ST_MEAS])
      else $error("measuring bit set while idle");
endmodule

// File: dscc_master_model.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////
// Link master stand-in: sends output words, keeps the latest input word
module dscc_master_model #(
   parameter int GAP_CLKS = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [31:0] device_input_word_i,
   input wire logic pd_in_strobe_i,
   output logic [7:0] master_output_word_o,
   output logic pd_out_valid_o
);
   logic [31:0] last_word_reg;
   int words_seen;
   initial begin
      master_output_word_o = 8'h00;
      pd_out_valid_o = 1'b0;
      words_seen = 0;
   end
   // Keep the word of the latest exchange; the device owns its content
   always @(posedge clk_i) begin
      if (rst_i) begin
         last_word_reg <= 32'h0000_0000;
      end else if (pd_in_strobe_i) begin
         last_word_reg <= device_input_word_i;
         words_seen++;
      end
   end
   // Only bit 0 means anything; reserved bits go out as 0
   task automatic send_out(input logic off_bit);
      @(posedge clk_i);
      master_output_word_o <= {7'h00, off_bit};
      pd_out_valid_o <= 1'b1;
      @(posedge clk_i);
      pd_out_valid_o <= 1'b0;
      // Spacing is shortened so the run stays short
      repeat (GAP_CLKS) @(posedge clk_i);
   endtask
endmodule

// File: tb_distance_sensor_cyclic_data_cmds.sv
`timescale 1ns/1ps
`include "dscc_defs.svh"
module tb_distance_sensor_cyclic_data_cmds;
   import dscc_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_wdat = 32'h0, wb_dat_o, rd_v, dev_word;
   logic wb_ack_o, wb_err_o, rd_e, pd_str, emitter_on_o, restart_o, factory_reset_o;
   logic upload_event_o, storage_accept_flag_o, cmd_error_o, out_valid;
   logic [7:0] out_word;
   logic meas_valid = 1'b0, meas_none = 1'b0, meas_trig = 1'b0, sig_ok = 1'b1, warn = 1'b0;
   logic ch_one = 1'b0, ch_two = 1'b0, startup = 1'b0, teaching = 1'b0, hw_level = 1'b0;
   logic [15:0] meas_dist = 16'h0000;
   int err_total = 0, samples_checked = 0, cyc_count = 0;
   int n_restart = 0, n_factory = 0, n_upload = 0;

   // 250 MHz clock
   always #2 clk_i = ~clk_i;

   dscc_core DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
      .master_output_word_i(out_word), .pd_out_valid_i(out_valid),
      .device_input_word_o(dev_word), .pd_in_strobe_o(pd_str), .meas_valid_i(meas_valid),
      .meas_dist_i(meas_dist), .meas_none_i(meas_none), .meas_trigger_i(meas_trig),
      .signal_ok_i(sig_ok), .warning_i(warn), .switch_channel_one_i(ch_one),
      .switch_channel_two_i(ch_two), .startup_i(startup), .teaching_i(teaching),
      .hw_input_level_i(hw_level), .emitter_on_o(emitter_on_o), .restart_o(restart_o),
      .factory_reset_o(factory_reset_o), .upload_event_o(upload_event_o),
      .storage_accept_flag_o(storage_accept_flag_o), .cmd_error_o(cmd_error_o));

   dscc_master_model MST (.clk_i(clk_i), .rst_i(rst_i), .device_input_word_i(dev_word),
      .pd_in_strobe_i(pd_str), .master_output_word_o(out_word), .pd_out_valid_o(out_valid));

   //////////////////////////////////////////////////////////////////////
   // Pulse tallies; a pulse seen twice would show up as a count of 2
   always @(posedge clk_i) begin
      if (restart_o === 1'b1) n_restart++;
      if (factory_reset_o === 1'b1) n_factory++;
      if (upload_event_o === 1'b1) n_upload++;
   end

   // Hang guard: the whole sequence needs well under 4000 cycles
   always @(posedge clk_i) begin
      cyc_count++;
      if (cyc_count == 20000) begin
         err_total++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t %s got %h want %h", $time, what, got, exp);
      end
   endtask

   //////////////////////////////////////////////////////////////////////
   // Classic cycle: hold until ack or err, take data at that edge only
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                          input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_sel <= sel;
      wb_wdat <= wd;
      // Answer is looked at on the rising edge; release follows at that same edge
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
      rd_v = wb_dat_o;
      rd_e = wb_err_o;
      if (n >= 50) check(1'b0, 1'b1, "bus answer");
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] adr);
      wb_xfer(1'b0, adr, 4'hF, 32'h0);
   endtask

   // Command lane is byte 0; effects land one edge after the write
   task automatic cmd(input logic [7:0] code);
      wb_xfer(1'b1, `DSCC_OFS_CMD, 4'h1, {24'h0, code});
      repeat (3) @(posedge clk_i);
   endtask

   task automatic meas(input logic [15:0] d);
      @(posedge clk_i);
      meas_dist <= d;
      meas_valid <= 1'b1;
      @(posedge clk_i);
      meas_valid <= 1'b0;
   endtask

   task automatic emit(input logic exp, input string what);
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      check(emitter_on_o, exp, what);
   endtask

   //////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      check(dev_word, 32'h0, "word after reset");
      check({storage_accept_flag_o, cmd_error_o, emitter_on_o}, 3'b001, "reset outs");
      rd(8'h3C);
      check(rd_e, 1'b1, "unmapped err");
      rd(`DSCC_OFS_SEL);
      check(rd_v[7:0], `DSCC_SEL_CH1A, "selector reset");
      $display("test reset done");
      // Per-channel teach through the selector
      meas(16'd1000);
      cmd(`DSCC_CMD_TEACH_FAR);
      wb_xfer(1'b1, `DSCC_OFS_SEL, 4'h1, {24'h0, `DSCC_SEL_CH2});
      meas(16'd2000);
      cmd(`DSCC_CMD_TEACH_FAR);
      rd(`DSCC_OFS_FARSP);
      check(rd_v, {16'd2000, 16'd1000}, "far per channel");
      wb_xfer(1'b1, `DSCC_OFS_SEL, 4'h1, {24'h0, `DSCC_SEL_BOTH});
      meas(16'd300);
      cmd(`DSCC_CMD_TEACH_NEAR);
      rd(`DSCC_OFS_NEARSP);
      check(rd_v, {16'd300, 16'd300}, "near both");
      cmd(`DSCC_CMD_TEACH_WIN);
      check(cmd_error_o, 1'b0, "window known");
      rd(`DSCC_OFS_FARSP);
      check(rd_v, {16'd1150, 16'd650}, "window far");
      cmd(`DSCC_CMD_TEACH_ALT);
      check(cmd_error_o, 1'b0, "alt known");
      rd(`DSCC_OFS_ALTSP);
      check(rd_v, {16'd300, 16'd300}, "alt both");
      $display("test teach done");
      meas(16'd500);
      cmd(`DSCC_CMD_ANA_MIN);
      meas(16'd3000);
      cmd(`DSCC_CMD_ANA_MAX);
      rd(`DSCC_OFS_ANALOG);
      check(rd_v, {16'd3000, 16'd500}, "analog range");
      wb_xfer(1'b1, `DSCC_OFS_PRESET, 4'h3, 32'd100);
      meas(16'd1000);
      cmd(`DSCC_CMD_PRESET);
      rd(`DSCC_OFS_OFFSET);
      check(rd_v[15:0], 16'hFC7C, "offset");
      meas(16'd1000);
      rd(`DSCC_OFS_MEAS);
      check(rd_v, 32'h0000_0064, "preset reading");
      $display("test capture done");
      // Forcing overrides the off bit until dropped
      MST.send_out(1'b1);
      emit(1'b0, "off bit");
      cmd(`DSCC_CMD_FORCE_ON);
      emit(1'b1, "forced on");
      MST.send_out(1'b0);
      cmd(`DSCC_CMD_FORCE_OFF);
      emit(1'b0, "forced off");
      cmd(`DSCC_CMD_STD_PRIO);
      emit(1'b1, "std prio");
      MST.send_out(1'b1);
      emit(1'b0, "off bit again");
      // Hardware input wins over every other source
      wb_xfer(1'b1, `DSCC_OFS_CTRL, 4'h1, 32'h2);
      cmd(`DSCC_CMD_FORCE_ON);
      emit(1'b0, "hw low wins");
      hw_level <= 1'b1;
      cmd(`DSCC_CMD_FORCE_OFF);
      emit(1'b1, "hw high wins");
      wb_xfer(1'b1, `DSCC_OFS_CTRL, 4'h1, 32'h0);
      cmd(`DSCC_CMD_STD_PRIO);
      MST.send_out(1'b0);
      emit(1'b1, "hw released");
      $display("test emitter done");
      // Storage flag, restart, factory values, refused code
      cmd(`DSCC_CMD_ACCEPT);
      check({storage_accept_flag_o, 8'(n_upload)}, {1'b1, 8'h01}, "accept");
      cmd(8'h55);
      check({cmd_error_o, storage_accept_flag_o}, 2'b11, "unknown code");
      cmd(`DSCC_CMD_RESTART);
      check({8'(n_restart), cmd_error_o, storage_accept_flag_o}, 10'h005, "restart");
      cmd(`DSCC_CMD_REVOKE);
      check(storage_accept_flag_o, 1'b0, "revoke");
      cmd(`DSCC_CMD_ACCEPT);
      cmd(`DSCC_CMD_FACTORY);
      check({8'(n_factory), storage_accept_flag_o}, 9'h002, "factory");
      rd(`DSCC_OFS_FARSP);
      check(rd_v, 32'h0, "factory setpoints");
      $display("test commands done");
      // Packed word, status bits and reserved distance codes
      ch_one <= 1'b1;
      warn <= 1'b1;
      meas_trig <= 1'b1;
      meas(16'h7EF4);
      rd(`DSCC_OFS_INWORD);
      check(rd_v, {`DSCC_DIST_ABOVE, `DSCC_SCALE_STD, 8'hB9}, "word above");
      teaching <= 1'b1;
      ch_one <= 1'b0;
      ch_two <= 1'b1;
      wb_xfer(1'b1, `DSCC_OFS_CTRL, 4'h1, 32'h1);
      meas(16'h810C);
      rd(`DSCC_OFS_INWORD);
      check(rd_v, {`DSCC_DIST_BELOW, `DSCC_SCALE_HR, 8'h12}, "word below");
      meas_none <= 1'b1;
      meas(16'h0000);
      rd(`DSCC_OFS_MEAS);
      check(rd_v, {16'h0000, `DSCC_DIST_NONE}, "no measurement");
      $display("test status done");
      give_verdict();
   end
endmodule
